/* File: common/clk_gen_pkg.sv */
// package: register map, reset values and divider figures of the clock unit
package clk_gen_pkg;
    // register index as printed; byte address on apb is four times the index
    localparam logic [23:0] GATES_INDEX = 24'h040902;
    localparam logic [23:0] GATES_ADDR = 24'(GATES_INDEX * 4);
    localparam logic [23:0] STATUS_INDEX = 24'h040904;
    localparam logic [23:0] STATUS_ADDR = 24'(STATUS_INDEX * 4);
    localparam logic [15:0] GATES_RESET = 16'h4003;
    // bits 13 and 2 are reserved: never stored, read as zero
    localparam logic [15:0] GATES_MASK = 16'hdffb;
    // enable bit positions
    localparam int BIT_IRDA_ESCAPE = 15;
    localparam int BIT_DSP = 14;
    localparam int BIT_DMA = 12;
    localparam int BIT_AUTOBAUD = 11;
    localparam int BIT_SERIAL_DATA_PORT = 10;
    localparam int BIT_DEBUG_PORT = 9;
    localparam int BIT_PULSE_GENERATOR_B = 8;
    localparam int BIT_PULSE_GENERATOR_A = 7;
    localparam int BIT_CRC = 6;
    localparam int BIT_TIMER_B = 5;
    localparam int BIT_PWM = 4;
    localparam int BIT_SIM = 3;
    localparam int BIT_BUS_INTERFACE_UNIT = 1;
    localparam int BIT_MCU_CORE = 0;
    // status register fields
    localparam int STATUS_LOCK_BIT = 16;
    // clock figures
    localparam int PCLK_KHZ = 250000;
    localparam int SYS_CLK_KHZ = 3900;
    localparam logic [1:0] PRESCALE = 2'h2;
    localparam logic [4:0] PLL_MULT = 5'h14;
    localparam logic [1:0] POSTDIV = 2'h2;
    // expected pclk cycles per prescaled period, start value of the loop
    localparam logic [15:0] NOMINAL_PERIOD =
        16'(PCLK_KHZ * int'(PRESCALE) / SYS_CLK_KHZ);
    localparam logic [1:0] LOCK_COUNT = 2'h2;
endpackage

/* File: hw/clock_gating_and_pll_dividers.sv */
// clock unit: per-block gated clocks, prescaler, pll model and postdivider
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// - take the 3.9 MHz system clock, buffer it, send it to every block.
// - every peripheral block has its own clock enable.
// - enable bit 1 runs that block's clock, 0 stops it.
// - after writing 0 the gated clock goes low at next falling edge.
// - after writing 1 the gated clock resumes at next rising edge.
// - 16-bit read/write enable register at 0040902, reset value 4003.
// - prescale the system clock by 2, a 2-bit factor, before the pll.
// - pll multiplies the prescaled clock by 20; output clocks dsp core.
// - pll output divided by 2 gives the microcontroller core clock.
// - bit map of blocks; bits 13 and 2 reserved.
module clock_gating_and_pll_dividers
    import clk_gen_pkg::*;
(
    input wire logic pclk, // apb clock, 250 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, 1 = write
    input wire logic [23:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic sys_clk_in, // 3.9 MHz system clock
    output logic sys_clk_buf, // buffered system clock
    output logic [15:0] block_clk, // gated clock per block
    output logic dsp_core_clk, // pll output
    output logic mcu_core_clk // pll output divided by postdivider
);
    import clk_gen_pkg::*;

    logic [15:0] block_clock_gates;
    logic [15:0] gate_active;
    logic [15:0] next_gate_active;
    logic sys_prev;
    logic sys_rise;
    logic sys_fall;
    logic [1:0] pre_cnt;
    logic pre_tick;
    logic [15:0] period_cnt;
    logic [15:0] period;
    logic [1:0] lock_cnt;
    logic [16:0] phase;
    logic [16:0] next_phase;
    logic dsp_toggle;
    logic dsp_rise;
    logic [1:0] post_cnt;
    logic apb_setup;
    logic apb_write;

    // decode used only by the error flag; the read mux compares the addresses itself
    function automatic logic mapped(input logic [23:0] a);
        return a == GATES_ADDR || a == STATUS_ADDR;
    endfunction

    // gate register decode, used by the write path and the read mux
    function automatic logic is_gates(input logic [23:0] a);
        return a == GATES_ADDR;
    endfunction

    // last count of the prescaler, used by the counter and by the tick
    function automatic logic pre_last(input logic [1:0] c);
        return c == PRESCALE - 2'h1;
    endfunction

    // last count of the postdivider: one half period of the mcu clock
    // spans POSTDIV / 2 rising edges of the pll output
    function automatic logic post_last(input logic [1:0] c);
        return c == POSTDIV / 2'h2 - 2'h1;
    endfunction

    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;
    // every access completes in its first access cycle
    assign pready = 1'b1;

    // system clock is sampled as a synchronous level; edges found from it
    // limitation: edges are seen one pclk late, so sys_clk_in must be slow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_prev <= 1'b0;
            sys_clk_buf <= 1'b0;
        end else begin
            sys_prev <= sys_clk_in;
            sys_clk_buf <= sys_clk_in;
        end
    end
    assign sys_rise = sys_clk_in && !sys_prev;
    assign sys_fall = !sys_clk_in && sys_prev;

    // enable register; reserved bits are never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_clock_gates <= GATES_RESET;
        end else if (apb_write && is_gates(paddr)) begin
            block_clock_gates <= pwdata[15:0] & GATES_MASK;
        end
    end

    // a stop takes hold only on a falling edge and a start only on a rising
    // edge, so the output never carries a cut phase
    always_comb begin
        next_gate_active = gate_active;
        if (sys_fall) begin
            next_gate_active = gate_active & block_clock_gates;
        end else if (sys_rise) begin
            next_gate_active = gate_active | block_clock_gates;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_active <= 16'h0000;
            block_clk <= 16'h0000;
        end else begin
            gate_active <= next_gate_active;
            // one and-gate per block, after the edge decision
            block_clk <= {16{sys_clk_in}}
                & next_gate_active;
        end
    end

    // prescaler: one tick every PRESCALE rising edges of the system clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt <= 2'h0;
        end else if (sys_rise) begin
            pre_cnt <= pre_last(pre_cnt) ? 2'h0 : pre_cnt + 2'h1;
        end
    end
    assign pre_tick = sys_rise && pre_last(pre_cnt);

    // loop reference: pclk cycles per prescaled period; the counter waits
    // at zero for the first tick, so the part period right after reset is
    // never taken as a measurement
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_cnt <= 16'h0000;
            period <= NOMINAL_PERIOD;
            lock_cnt <= 2'h0;
        end else if (pre_tick) begin
            period_cnt <= 16'h0001;
            if (period_cnt != 16'h0000) begin
                period <= period_cnt;
            end
            if (lock_cnt != LOCK_COUNT) begin
                lock_cnt <= lock_cnt + 2'h1;
            end
        end else if (period_cnt != 16'h0000 && period_cnt != 16'hffff) begin
            period_cnt <= period_cnt + 16'h0001;
        end
    end

    // digital oscillator: 2*PLL_MULT half periods per reference period
    // edges fall on the pclk grid, so single phases differ by one pclk;
    // only the average frequency over a reference period is exact
    always_comb begin
        next_phase = phase + 17'({PLL_MULT, 1'b0});
        dsp_toggle = 1'b0;
        if (next_phase >= {1'b0, period}) begin
            next_phase = next_phase - {1'b0, period};
            dsp_toggle = 1'b1;
        end
    end

    // the oscillator realigns to the reference each prescaled period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 17'h00000;
            dsp_core_clk <= 1'b0;
        end else if (pre_tick) begin
            phase <= 17'h00000;
            dsp_core_clk <= 1'b1;
        end else begin
            phase <= next_phase;
            dsp_core_clk <= dsp_core_clk ^ dsp_toggle;
        end
    end

    // a rising edge of the pll output is due at this pclk edge, either
    // from the realignment or from an ordinary toggle
    assign dsp_rise = !dsp_core_clk && (pre_tick || dsp_toggle);

    // postdivider counts rising edges of the pll output; the mcu clock
    // changes level only together with a dsp rise, so both stay aligned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_cnt <= 2'h0;
            mcu_core_clk <= 1'b0;
        end else if (dsp_rise) begin
            if (post_last(post_cnt)) begin
                post_cnt <= 2'h0;
                mcu_core_clk <= ~mcu_core_clk;
            end else begin
                post_cnt <= post_cnt + 2'h1;
            end
        end
    end

    // read data and error are captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            pslverr <= !mapped(paddr);
            if (is_gates(paddr)) begin
                prdata <= {16'h0000, block_clock_gates};
            end else if (paddr == STATUS_ADDR) begin
                // the loop's own measurement, so software can see lock
                prdata <= {15'h0000, lock_cnt == LOCK_COUNT, period};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end
endmodule // clock_gating_and_pll_dividers

/* File: verification/clk_unit_asserts.sv */
// checker: timing relations at the clock unit ports
`timescale 1ns/1ps
module clk_unit_checker (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic [23:0] paddr, // address
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic sys_clk_in, // sys clock
    input wire logic sys_clk_buf, // buffered
    input wire logic [15:0] block_clk, // gated
    input wire logic dsp_core_clk, // dsp
    input wire logic mcu_core_clk // mcu
);
    import clk_gen_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    buf_delay_a: assert property (sys_clk_buf == $past(sys_clk_in))
        else $error("buffer delay wrong");
    gate_low_a: assert property ((block_clk & ~{16{sys_clk_buf}}) == 0)
        else $error("gated clock high while sys low");
    rise_align_a: assert property (|(block_clk & ~$past(block_clk))
        |-> $rose(sys_clk_buf)) else $error("gated rise misaligned");
    fall_align_a: assert property (|(~block_clk & $past(block_clk))
        |-> $fell(sys_clk_buf)) else $error("gated fall misaligned");
    reserved_low_a: assert property (!block_clk[13] && !block_clk[2])
        else $error("reserved clock active");
    ready_high_a: assert property (pready)
        else $error("pready low");
    unmapped_err_a: assert property (psel && penable |-> pslverr ==
        (paddr != GATES_ADDR && paddr != STATUS_ADDR)) else $error("bad err");
    mcu_half_a: assert property ($changed(mcu_core_clk)
        |-> $rose(dsp_core_clk)) else $error("mcu edge without dsp rise");
    cover property ($rose(block_clk[5]));
    cover property ($fell(block_clk[5]));
    cover property (psel && penable && pslverr);
endmodule // clk_unit_checker
bind clock_gating_and_pll_dividers clk_unit_checker chk_u (.pclk, .presetn,
    .psel, .penable, .paddr, .pready, .pslverr, .sys_clk_in, .sys_clk_buf,
    .block_clk, .dsp_core_clk, .mcu_core_clk);

/* File: verification/clock_gating_and_pll_dividers_tb_top.sv */
// testbench: registers, gating and dividers of the clock unit
`timescale 1ns/1ps
module clock_gating_and_pll_dividers_tb_top;
    import clk_gen_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slverr;
    logic [23:0] paddr = 24'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, sys_clk_in, sys_clk_buf, dsp_core_clk, mcu_core_clk;
    logic [15:0] block_clk;
    logic [4:0] sig;
    int err_count = 0, check_count = 0, n[5];
    assign sig = {mcu_core_clk, dsp_core_clk, sys_clk_buf, block_clk[5:4]};
    sys_clock_source src_u (.pclk, .presetn, .sys_clk_in);
    clock_gating_and_pll_dividers dut_u (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sys_clk_in,
        .sys_clk_buf, .block_clk, .dsp_core_clk, .mcu_core_clk);
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(logic wr, logic [23:0] a, logic [31:0] d);
        int i;
        i = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && i < 20) begin
            i++;
            @(posedge pclk);
        end
        if (i < 20) begin
            rd = prdata;
            slverr = pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (i == 20) begin
            err_count++;
            stop_test();
        end
    endtask
    // rising edges of the watched clocks over a fixed window
    task automatic count_rises(int cycles);
        logic [4:0] prev;
        n = '{default: 0};
        prev = sig;
        repeat (cycles) begin
            @(posedge pclk);
            for (int k = 0; k < 5; k++) n[k] += int'(sig[k] & ~prev[k]);
            prev = sig;
        end
    endtask
    task automatic t_regs();
        apb(0, GATES_ADDR, 0);
        check("gates reset", rd, 32'h4003);
        apb(1, GATES_ADDR, 32'hffffffff);
        apb(0, GATES_ADDR, 0);
        check("gates rw", rd, 32'hdffb);
        apb(1, 24'h10240c, 0);
        apb(0, 24'h10240c, 0);
        check("unmapped err", 32'(slverr), 1);
        check("unmapped data", rd, 0);
        apb(0, GATES_ADDR, 0);
        check("gates kept", rd, 32'hdffb);
        check("mapped err", 32'(slverr), 0);
    endtask
    task automatic t_gate();
        apb(1, GATES_ADDR, 32'hdfdb);
        // a high phase begun before the next sys fall may still finish
        count_rises(64);
        check("bit5 last phase", 32'(n[1] <= 1), 1);
        count_rises(256);
        check("bit5 stopped", 32'(n[1]), 0);
        check("bit5 low", 32'(block_clk[5]), 0);
        check("bit4 runs", 32'(n[0]), 4);
        check("buffered", 32'(n[2]), 4);
        apb(1, GATES_ADDR, 32'hdffb);
        count_rises(256);
        check("bit5 resumed", 32'(n[1]), 4);
    endtask
    task automatic t_pll();
        count_rises(1280);
        check("dsp rises", 32'(n[3] >= 199 && n[3] <= 201), 1);
        check("mcu rises", 32'(n[4] >= 99 && n[4] <= 101), 1);
        apb(0, STATUS_ADDR, 0);
        check("status", rd, {15'h0000, 1'b1, NOMINAL_PERIOD});
    endtask
    initial begin
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_gate();
        t_pll();
        stop_test();
    end
endmodule // clock_gating_and_pll_dividers_tb_top

/* File: verification/sys_clock_source.sv */
// model: system clock source driving the clock unit
`timescale 1ns/1ps
module sys_clock_source (
    input wire logic pclk, // bench clock
    input wire logic presetn, // reset, active low
    output logic sys_clk_in // square wave
);
    logic [4:0] half_count;
    // 32 pclk per half is 3.906 MHz, the closest a 4 ns grid allows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_count <= 5'h0;
            sys_clk_in <= 1'b0;
        end else begin
            half_count <= half_count + 5'h1;
            if (half_count == 5'h1f) sys_clk_in <= ~sys_clk_in;
        end
    end
endmodule // sys_clock_source
